// >>> common/osc_stop_cfg.svh
`ifndef OSC_STOP_CFG_SVH
`define OSC_STOP_CFG_SVH
// Overview of operation
// - Event timer A may count its own event pin instead of the peripheral clock.
// - Cascade event timer may count its own event pin instead of the peripheral clock.
// - Cascade timer output may clock event timer A, forming a 24-bit event counter.
// - In the 24-bit arrangement the gating timer output enables or blocks the event input.
// - main_clock_status shows 0 for internal oscillator, 1 for high-speed system clock.
// - cpu_clock_status shows 0 for main system clock, 1 for subsystem clock.

// ==========================================================================
// Register byte offsets.
`define MAIN_CLK_MODE_OFFSET 8'h00
`define PROC_CLK_CTRL_OFFSET 8'h04
`define OSC_CTRL_OFFSET 8'h08
`define EVT_CTRL_OFFSET 8'h0C

// ==========================================================================
// Field positions.
`define MAIN_SEL_BIT     0
`define MAIN_STATUS_BIT  1
`define CPU_SEL_BIT      4
`define CPU_STATUS_BIT   5
`define OSC_INT_STOP_BIT 0
`define OSC_HS_STOP_BIT  1
`define OSC_SUBSEL_BIT  2
`define EVT_A_EXT_BIT   0
`define EVT_B_EXT_BIT   1
`define EVT_CASCADE_BIT 2
`define EVT_GATE_BIT    3

// ==========================================================================
// Reset values.
`define OSC_CTRL_RESET  3'h2
`define EVT_CTRL_RESET  4'h0
`endif

// >>> common/osc_stop_pkg.sv
package osc_stop_pkg;
  // AXI response code.
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_DECERR = 2'h3
  } axi_resp_t;

  // Register address field of the bus.
  typedef logic [7:0] reg_addr_t;
endpackage : osc_stop_pkg

// >>> verif/oscillator_stop_interlock_test.sv
`include "osc_stop_cfg.svh"

module oscillator_stop_interlock_test;
  timeunit 1ns;
  timeprecision 100ps;
  import osc_stop_pkg::*;

  // ==========================================================================
  // Stimulus and observed signals.
  logic        aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  reg_addr_t   awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [3:0]  wstrb;
  axi_resp_t   bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, periph_tick, gating_timer_out;
  logic        event_timer_a_input_pin, event_timer_b_input_pin, cascade_event_timer_out;
  logic        timer_a_count, timer_b_count, internal_osc_en, high_speed_clk_en;
  logic        subsystem_osc_en, main_clock_status, cpu_clock_status, counting;
  int          error_cnt, tests_run, cyc, cnt_a, cnt_b, ticks, rise_a, rise_b, pulses;

  oscillator_stop_interlock oscillator_stop_interlock_i (.aclk, .aresetn, .ce, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .periph_tick, .event_timer_a_input_pin, .event_timer_b_input_pin,
    .cascade_event_timer_out, .gating_timer_out, .timer_a_count, .timer_b_count, .internal_osc_en,
    .high_speed_clk_en, .subsystem_osc_en, .main_clock_status, .cpu_clock_status);

  // Clock of 8 ns period.
  always #4 aclk = ~aclk;

  // Count output pulses inside a window and cut a hang short.
  always @(posedge aclk) begin
    cyc++;
    if (counting) begin
      cnt_a += (timer_a_count === 1'h1);
      cnt_b += (timer_b_count === 1'h1);
    end
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ==========================================================================
  // Helper functions and tasks.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected pulse count on timer A (b = 0) or the cascade timer (b = 1).
  function automatic logic [31:0] exp_cnt(input logic [3:0] evt, input logic g, input logic b);
    if (!b) return evt[2] ? pulses : (evt[0] ? rise_a : ticks);
    if (!evt[1]) return ticks;
    return (evt[2] && evt[3] && !g) ? 32'h0 : rise_b;
  endfunction : exp_cnt

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input reg_addr_t a, input logic [31:0] d, input axi_resp_t er);
    @(posedge aclk);
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    awaddr  <= a;
    wdata   <= d;
    bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input reg_addr_t a, input logic [31:0] ed, input axi_resp_t er);
    @(posedge aclk);
    arvalid <= 1'h1;
    araddr  <= a;
    rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd

  // Drive random ticks and cascade pulses and periodic pin edges, then compare counts.
  task automatic run_events(input logic [3:0] evt);
    logic g;
    g = (evt[3:1] == 3'h7) ? evt[0] : seed[5];
    gating_timer_out <= g;
    wr(`EVT_CTRL_OFFSET, {28'h0, evt}, RESP_OKAY);
    {cnt_a, cnt_b, ticks, rise_a, rise_b, pulses} = '0;
    counting = 1'h1;
    for (int i = 0; i < 48; i++) begin
      @(posedge aclk);
      seed = lfsr(seed);
      periph_tick <= seed[0];
      ticks += seed[0];
      cascade_event_timer_out <= seed[3];
      pulses += seed[3];
      event_timer_a_input_pin <= (i % 6) < 3;
      rise_a += (i % 6 == 0);
      event_timer_b_input_pin <= (i % 8) < 4;
      rise_b += (i % 8 == 0);
    end
    @(posedge aclk);
    periph_tick <= 1'h0;
    cascade_event_timer_out <= 1'h0;
    repeat (8) @(posedge aclk);
    counting = 1'h0;
    chk(cnt_a, exp_cnt(evt, g, 1'h0));
    chk(cnt_b, exp_cnt(evt, g, 1'h1));
  endtask : run_events

  task automatic stop_test();
    $display("errors %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Main sequence.
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, periph_tick, gating_timer_out} = '0;
    {event_timer_a_input_pin, event_timer_b_input_pin, cascade_event_timer_out, counting} = '0;
    {awaddr, araddr, wdata, error_cnt, tests_run, cyc} = '0;
    ce    = 1'h1;
    wstrb = 4'hF;
    seed  = 32'h00015C57;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    // Reset values, then an unmapped place.
    chk({29'h0, internal_osc_en, high_speed_clk_en, subsystem_osc_en}, 32'h4);
    rd(`OSC_CTRL_OFFSET, {29'h0, `OSC_CTRL_RESET}, RESP_OKAY);
    rd(`EVT_CTRL_OFFSET, {28'h0, `EVT_CTRL_RESET}, RESP_OKAY);
    rd(`MAIN_CLK_MODE_OFFSET, 32'h0, RESP_OKAY);
    rd(`PROC_CLK_CTRL_OFFSET, 32'h0, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_DECERR);
    wr(8'h10, 32'hFF, RESP_DECERR);
    // A write without byte lane 0 leaves the register alone.
    wstrb <= 4'hE;
    wr(`OSC_CTRL_OFFSET, 32'h0, RESP_OKAY);
    rd(`OSC_CTRL_OFFSET, {29'h0, `OSC_CTRL_RESET}, RESP_OKAY);
    wstrb <= 4'hF;
    wr(`OSC_CTRL_OFFSET, 32'h0, RESP_OKAY);
    chk({30'h0, internal_osc_en, high_speed_clk_en}, 32'h3);
    wr(`MAIN_CLK_MODE_OFFSET, 32'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, main_clock_status}, 32'h1);
    rd(`MAIN_CLK_MODE_OFFSET, 32'h3, RESP_OKAY);
    wr(`MAIN_CLK_MODE_OFFSET, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, main_clock_status}, 32'h0);
    wr(`OSC_CTRL_OFFSET, 32'h4, RESP_OKAY);
    chk({31'h0, subsystem_osc_en}, 32'h1);
    wr(`PROC_CLK_CTRL_OFFSET, 32'h10, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, cpu_clock_status}, 32'h1);
    rd(`PROC_CLK_CTRL_OFFSET, 32'h30, RESP_OKAY);
    wr(`PROC_CLK_CTRL_OFFSET, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, cpu_clock_status}, 32'h0);
    // internal oscillator stopped only while main clock is high-speed.
    wr(`MAIN_CLK_MODE_OFFSET, 32'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    wr(`OSC_CTRL_OFFSET, 32'h5, RESP_OKAY);
    chk({31'h0, internal_osc_en}, 32'h0);
    wr(`MAIN_CLK_MODE_OFFSET, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, main_clock_status}, 32'h1);
    // high-speed clock stopped only once main clock is back on internal.
    wr(`OSC_CTRL_OFFSET, 32'h4, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, main_clock_status}, 32'h0);
    wr(`OSC_CTRL_OFFSET, 32'h6, RESP_OKAY);
    chk({31'h0, high_speed_clk_en}, 32'h0);
    wr(`MAIN_CLK_MODE_OFFSET, 32'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, main_clock_status}, 32'h0);
    // subsystem oscillator stopped only while CPU is on main clock.
    wr(`OSC_CTRL_OFFSET, 32'h2, RESP_OKAY);
    chk({31'h0, subsystem_osc_en}, 32'h0);
    wr(`PROC_CLK_CTRL_OFFSET, 32'h10, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, cpu_clock_status}, 32'h0);
    wr(`PROC_CLK_CTRL_OFFSET, 32'h0, RESP_OKAY);
    wr(`MAIN_CLK_MODE_OFFSET, 32'h0, RESP_OKAY);
    // Clock enable low freezes the count path, which resumes once it returns.
    ce          <= 1'h0;
    periph_tick <= 1'h1;
    repeat (3) @(posedge aclk);
    chk({31'h0, timer_a_count}, 32'h0);
    ce <= 1'h1;
    repeat (2) @(posedge aclk);
    chk({31'h0, timer_a_count}, 32'h1);
    periph_tick <= 1'h0;
    // all 16 event control settings, comparing the counts of timer A and the cascade timer.
    for (int k = 0; k < 16; k++) run_events(k[3:0]);
    stop_test();
  end
endmodule : oscillator_stop_interlock_test

// >>> verilog/oscillator_stop_interlock.sv
`include "osc_stop_cfg.svh"

module oscillator_stop_interlock (
  input  wire  logic                   aclk,              // System clock, 125 MHz.
  input  wire  logic                   aresetn,           // Synchronous reset, active low.
  input  wire  logic                   ce,                // Clock enable; state freezes while low.
  input  wire  logic                   awvalid,           // Write address valid.
  output logic                         awready,           // Write address ready.
  input  wire  osc_stop_pkg::reg_addr_t awaddr,           // Write byte address.
  input  wire  logic                   wvalid,            // Write data valid.
  output logic                         wready,            // Write data ready.
  input  wire  logic [31:0]            wdata,             // Write data.
  input  wire  logic [3:0]             wstrb,             // Write byte strobes.
  output logic                         bvalid,            // Write response valid.
  input  wire  logic                   bready,            // Write response ready.
  output osc_stop_pkg::axi_resp_t      bresp,             // Write response code.
  input  wire  logic                   arvalid,           // Read address valid.
  output logic                         arready,           // Read address ready.
  input  wire  osc_stop_pkg::reg_addr_t araddr,           // Read byte address.
  output logic                         rvalid,            // Read data valid.
  input  wire  logic                   rready,            // Read data ready.
  output logic [31:0]                  rdata,             // Read data.
  output osc_stop_pkg::axi_resp_t      rresp,             // Read response code.
  input  wire  logic                   periph_tick,       // Peripheral hardware clock tick.
  input  wire  logic                   event_timer_a_input_pin, // Event pin of timer A.
  input  wire  logic                   event_timer_b_input_pin, // Event pin of cascade timer.
  input  wire  logic                   cascade_event_timer_out, // Cascade timer output pulse.
  input  wire  logic                   gating_timer_out,  // Gating timer output level.
  output logic                         timer_a_count,     // Count pulse to timer A.
  output logic                         timer_b_count,     // Count pulse to cascade timer.
  output logic                         internal_osc_en,   // Internal high-speed oscillator run.
  output logic                         high_speed_clk_en, // Crystal and external input enable.
  output logic                         subsystem_osc_en,  // Subsystem crystal run.
  output logic                         main_clock_status, // 1 when main clock is high-speed.
  output logic                         cpu_clock_status   // 1 when CPU runs on subsystem.
);
  import osc_stop_pkg::*;

  // ========================================================================
  // Bus state.
  logic        aw_full_reg, w_full_reg;
  reg_addr_t   aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  axi_resp_t   bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  // Control and status registers.
  logic       main_sel_reg, cpu_sel_reg;
  logic [2:0] osc_ctrl_reg;
  logic [3:0] evt_ctrl_reg;
  logic       main_status_reg, cpu_status_reg;
  logic       int_osc_en_reg, hs_clk_en_reg;

  // Pin synchronisers and edge stage.
  logic [2:0] pin_a_sync_reg, pin_b_sync_reg;
  logic       count_a_reg, count_b_reg;

  // Word index check for a byte address.
  function automatic logic is_reg(input reg_addr_t a, input reg_addr_t off);
    is_reg = (a[7:2] == off[7:2]);
  endfunction : is_reg

  // Whether an address lands on a mapped register.
  function automatic logic is_mapped(input reg_addr_t a);
    is_mapped = is_reg(a, `MAIN_CLK_MODE_OFFSET) | is_reg(a, `PROC_CLK_CTRL_OFFSET) |
                is_reg(a, `OSC_CTRL_OFFSET) | is_reg(a, `EVT_CTRL_OFFSET);
  endfunction : is_mapped

  // ========================================================================
  // Write channel capture; address and data are taken in either order.
  wire aw_take   = awvalid & awready_reg;
  wire w_take    = wvalid & wready_reg;
  wire aw_have   = aw_full_reg | aw_take;
  wire w_have    = w_full_reg | w_take;
  wire wr_fire   = aw_have & w_have & ~bvalid_reg;
  wire b_done    = bvalid_reg & bready;
  wire reg_addr_t wr_addr = aw_full_reg ? aw_addr_reg : awaddr;
  wire [31:0]  wr_data    = w_full_reg ? w_data_reg : wdata;
  wire [3:0]   wr_strb    = w_full_reg ? w_strb_reg : wstrb;
  wire aw_full_next = aw_have & ~wr_fire;
  wire w_full_next  = w_have & ~wr_fire;
  wire bvalid_next  = wr_fire | (bvalid_reg & ~bready);

  // Register write strobes; all fields sit in byte lane 0.
  wire lane0   = wr_fire & wr_strb[0];
  wire wr_main_mode = lane0 & is_reg(wr_addr, `MAIN_CLK_MODE_OFFSET);
  wire wr_proc_ctrl = lane0 & is_reg(wr_addr, `PROC_CLK_CTRL_OFFSET);
  wire wr_osc  = lane0 & is_reg(wr_addr, `OSC_CTRL_OFFSET);
  wire wr_evt  = lane0 & is_reg(wr_addr, `EVT_CTRL_OFFSET);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else if (ce) begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= ~aw_full_next & ~bvalid_next;
      wready_reg  <= ~w_full_next & ~bvalid_next;
      bvalid_reg  <= bvalid_next;
      if (wr_fire) begin
        bresp_reg <= is_mapped(wr_addr) ? RESP_OKAY : RESP_DECERR;
      end
    end
  end

  // Holding registers for a channel taken before its partner.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else if (ce) begin
      if (aw_take) aw_addr_reg <= awaddr;
      if (w_take) begin
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
    end
  end

  // ========================================================================
  // Read channel; data are answered the cycle after the address is taken.
  wire ar_take = arvalid & arready_reg;
  wire rvalid_next = ar_take | (rvalid_reg & ~rready);
  wire [31:0] rd_word =
    is_reg(araddr, `MAIN_CLK_MODE_OFFSET) ?
      (32'(main_status_reg) << `MAIN_STATUS_BIT) | (32'(main_sel_reg) << `MAIN_SEL_BIT) :
    is_reg(araddr, `PROC_CLK_CTRL_OFFSET) ?
      (32'(cpu_status_reg) << `CPU_STATUS_BIT) | (32'(cpu_sel_reg) << `CPU_SEL_BIT) :
    is_reg(araddr, `OSC_CTRL_OFFSET) ? 32'(osc_ctrl_reg) :
    is_reg(araddr, `EVT_CTRL_OFFSET) ? 32'(evt_ctrl_reg) : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else if (ce) begin
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= rd_word;
        rresp_reg <= is_mapped(araddr) ? RESP_OKAY : RESP_DECERR;
      end
    end
  end

  // ========================================================================
  // Source selects; a select takes effect only once its target clock runs, except that the CPU returns to the main clock at once.
  wire main_status_next = (main_sel_reg & ~osc_ctrl_reg[`OSC_HS_STOP_BIT]) ? 1'b1 :
                          (~main_sel_reg & ~osc_ctrl_reg[`OSC_INT_STOP_BIT]) ? 1'b0 :
                          main_status_reg;
  wire cpu_status_next  = (cpu_sel_reg & osc_ctrl_reg[`OSC_SUBSEL_BIT]) ? 1'b1 :
                          ~cpu_sel_reg ? 1'b0 : cpu_status_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_sel_reg    <= 1'b0;
      cpu_sel_reg     <= 1'b0;
      osc_ctrl_reg    <= `OSC_CTRL_RESET;
      evt_ctrl_reg    <= `EVT_CTRL_RESET;
      main_status_reg <= 1'b0;
      cpu_status_reg  <= 1'b0;
      // Enable flops mirror the reset stop bits so the pins come from flops.
      int_osc_en_reg  <= ~1'(`OSC_CTRL_RESET >> `OSC_INT_STOP_BIT);
      hs_clk_en_reg   <= ~1'(`OSC_CTRL_RESET >> `OSC_HS_STOP_BIT);
    end else if (ce) begin
      if (wr_main_mode) main_sel_reg <= wr_data[`MAIN_SEL_BIT];
      if (wr_proc_ctrl) cpu_sel_reg <= wr_data[`CPU_SEL_BIT];
      if (wr_osc) begin
        osc_ctrl_reg   <= wr_data[2:0];
        int_osc_en_reg <= ~wr_data[`OSC_INT_STOP_BIT];
        hs_clk_en_reg  <= ~wr_data[`OSC_HS_STOP_BIT];
      end
      if (wr_evt) evt_ctrl_reg <= wr_data[3:0];
      main_status_reg <= main_status_next;
      cpu_status_reg  <= cpu_status_next;
    end
  end

  // ========================================================================
  // Event count clock selection.
  wire edge_a = pin_a_sync_reg[1] & ~pin_a_sync_reg[2];
  wire edge_b = pin_b_sync_reg[1] & ~pin_b_sync_reg[2];
  wire cascade_on = evt_ctrl_reg[`EVT_CASCADE_BIT];
  wire gate_open = ~(cascade_on & evt_ctrl_reg[`EVT_GATE_BIT]) | gating_timer_out;
  wire count_b_next = evt_ctrl_reg[`EVT_B_EXT_BIT] ? (edge_b & gate_open) : periph_tick;
  wire count_a_next = cascade_on ? cascade_event_timer_out :
                      evt_ctrl_reg[`EVT_A_EXT_BIT] ? edge_a : periph_tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_a_sync_reg <= 3'h0;
      pin_b_sync_reg <= 3'h0;
      count_a_reg    <= 1'b0;
      count_b_reg    <= 1'b0;
    end else if (ce) begin
      pin_a_sync_reg <= {pin_a_sync_reg[1:0], event_timer_a_input_pin};
      pin_b_sync_reg <= {pin_b_sync_reg[1:0], event_timer_b_input_pin};
      count_a_reg    <= count_a_next;
      count_b_reg    <= count_b_next;
    end
  end

  // ========================================================================
  // Output drive.
  assign awready           = awready_reg;
  assign wready            = wready_reg;
  assign bvalid            = bvalid_reg;
  assign bresp             = bresp_reg;
  assign arready           = arready_reg;
  assign rvalid            = rvalid_reg;
  assign rdata             = rdata_reg;
  assign rresp             = rresp_reg;
  assign timer_a_count     = count_a_reg;
  assign timer_b_count     = count_b_reg;
  assign internal_osc_en   = int_osc_en_reg;
  assign high_speed_clk_en = hs_clk_en_reg;
  assign subsystem_osc_en  = osc_ctrl_reg[`OSC_SUBSEL_BIT];
  assign main_clock_status = main_status_reg;
  assign cpu_clock_status  = cpu_status_reg;

  // ========================================================================
  // Checks on the count paths and status bits.
  a_timer_a_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !cascade_on && evt_ctrl_reg[`EVT_A_EXT_BIT] ##1 ce |-> timer_a_count == $past(edge_a))
    else $error("Timer A count does not follow its event pin.");
  a_timer_b_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && evt_ctrl_reg[`EVT_B_EXT_BIT] && gate_open && edge_b |=> timer_b_count)
    else $error("Cascade timer missed an event pin edge.");
  a_cascade_path: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && cascade_on && cascade_event_timer_out |=> timer_a_count)
    else $error("Cascade output did not reach timer A.");
  a_gate_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && cascade_on && evt_ctrl_reg[`EVT_B_EXT_BIT] && evt_ctrl_reg[`EVT_GATE_BIT]
      && !gating_timer_out |=> !timer_b_count)
    else $error("Closed gate let an event through.");
  a_main_status: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && main_sel_reg && high_speed_clk_en |=> main_clock_status)
    else $error("Main status did not move to high-speed clock.");
  a_cpu_status: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !cpu_sel_reg |=> !cpu_clock_status)
    else $error("CPU status did not return to main clock.");
  a_ce_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
    !ce |=> $stable({timer_a_count, timer_b_count, main_clock_status, cpu_clock_status, awready, rvalid}))
    else $error("State moved while clock enable was low.");
  c_write_done: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire ##[1:4] b_done);
  c_cascade: cover property (@(posedge aclk) disable iff (!aresetn) cascade_on && timer_a_count);
  c_to_sub: cover property (@(posedge aclk) disable iff (!aresetn) $rose(cpu_clock_status));
endmodule : oscillator_stop_interlock
